// ---- bench/apb_master_model.sv ----
// Purpose: APB master standing for the processor or DMA controller on the bus.
// Assumes: The slave updates its outputs only on the rising edge.
// Notes: Released address and data show the inverse of their last value.
`timescale 1ns/100ps
module apb_master_model (
  // Clock.
  input wire logic clk_i,
  // Slave answer.
  input wire logic pready_i,
  input wire crc_pkg::word_t prdata_i,
  input wire logic pslverr_i,
  // Request.
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output crc_pkg::word_t pwdata_o,
  output logic [3:0] pstrb_o
);
  import crc_pkg::*;
  logic held;

  initial begin
    held = 1'b0;
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h00000000;
    pstrb_o = 4'h0;
  end

  // ==========================================================================
  // One transfer; hold keeps the select up so the next setup follows at once.
  task automatic xfer(input logic wr, input logic [11:0] a, input word_t d, input logic [3:0] s,
                      input logic hold, output word_t rd, output logic err);
    if (!held) begin
      @(posedge clk_i);
    end
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    pstrb_o <= s;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_i !== 1'b1);
    rd = prdata_i;
    err = pslverr_i;
    held = hold;
    if (!hold) begin
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      paddr_o <= ~a;
      pwdata_o <= ~d;
    end
  endtask
endmodule

// ---- bench/test_crc_engine.sv ----
// Purpose: Self-checking bench of the CRC engine.
// Assumes: Accesses go through the APB master model.
// Notes: Expected sums of the mode tests come from a bitwise reference fold; the unit test uses fixed values.
`timescale 1ns/100ps
`include "crc_defs.svh"
module test_crc_engine;
  import crc_pkg::*;
  logic CLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O, BUSY_O;
  logic [11:0] PADDR_I;
  logic [3:0] PSTRB_I;
  word_t PWDATA_I, PRDATA_O;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [5:0] modes [9] = '{6'h00, 6'h01, 6'h02, 6'h0E, 6'h3D, 6'h32, 6'h21, 6'h03, 6'h13};

  always #5 CLK_I = ~CLK_I;

  crc_engine u_dut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .BUSY_O(BUSY_O));

  apb_master_model u_master (.clk_i(CLK_I), .pready_i(PREADY_O), .prdata_i(PRDATA_O),
    .pslverr_i(PSLVERR_O), .psel_o(PSEL_I), .penable_o(PENABLE_I), .pwrite_o(PWRITE_I),
    .paddr_o(PADDR_I), .pwdata_o(PWDATA_I), .pstrb_o(PSTRB_I));

  // ==========================================================================
  // Reference model.
  function automatic word_t fold(word_t c, logic [7:0] b, logic [5:0] m);
    word_t p;
    logic fb;
    p = (m[1:0] == 2'b10) ? `CRC_POLY_32 : (m[1:0] == 2'b01) ? `CRC_POLY_16 : `CRC_POLY_CCITT;
    if (m[2]) b = {<<{b}};
    if (m[3]) b = ~b;
    for (int i = 7; i >= 0; i--) begin
      fb = ((m[1:0] == 2'b10) ? c[31] : c[15]) ^ b[i];
      c = (c << 1) ^ (fb ? p : 32'h00000000);
      if (m[1:0] != 2'b10) c[31:16] = 16'h0000;
    end
    return c;
  endfunction

  function automatic word_t shown(word_t c, logic [5:0] m);
    word_t r, v;
    logic [15:0] h;
    v = {<<{c}};
    h = {<<{c[15:0]}};
    r = c;
    if (m[4]) r = (m[1:0] == 2'b10) ? v : {16'h0000, h};
    if (m[5]) r = (m[1:0] == 2'b10) ? ~r : {16'h0000, ~r[15:0]};
    return r;
  endfunction

  // ==========================================================================
  // Checks and verdict.
  task automatic check(word_t seen, word_t exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    word_t rd;
    logic err;
    u_master.xfer(1'b0, `CRC_OFS_SUM, 32'h0, 4'h0, 1'b1, rd, err);
    check(rd, `CRC_SUM_RST);
    u_master.xfer(1'b0, `CRC_OFS_MODE, 32'h0, 4'h0, 1'b1, rd, err);
    check(rd, 32'h00000000);
    u_master.xfer(1'b0, 12'h010, 32'h0, 4'h0, 1'b1, rd, err);
    check({31'h0, err}, 32'h00000001);
    u_master.xfer(1'b1, `CRC_OFS_SUM, 32'h0, 4'hF, 1'b0, rd, err);
    check({31'h0, err}, 32'h00000001);
    $display("test reset done");
  endtask

  task automatic t_mode(logic [5:0] m);
    logic [7:0] bs [7] = '{8'h01, 8'h80, 8'hA5, 8'hC3, 8'h96, 8'h3C, 8'h71};
    word_t rd, c;
    logic err;
    c = (m[1:0] == 2'b10) ? 32'h5A5A1D0F : 32'h00001D0F;
    u_master.xfer(1'b1, `CRC_OFS_MODE, {26'h0, m}, 4'hF, 1'b1, rd, err);
    u_master.xfer(1'b0, `CRC_OFS_MODE, 32'h0, 4'h0, 1'b1, rd, err);
    check(rd, {26'h0, m});
    u_master.xfer(1'b1, `CRC_OFS_SEED, 32'h12345678, 4'hF, 1'b1, rd, err);
    u_master.xfer(1'b1, `CRC_OFS_DATA, 32'hFFFFFFFF, 4'hF, 1'b1, rd, err);
    u_master.xfer(1'b1, `CRC_OFS_SEED, 32'h5A5A1D0F, 4'h1, 1'b1, rd, err);
    u_master.xfer(1'b1, `CRC_OFS_DATA, 32'hC3A58001, 4'hF, 1'b1, rd, err);
    u_master.xfer(1'b1, `CRC_OFS_DATA, 32'hAAAA3C96, 4'h3, 1'b1, rd, err);
    u_master.xfer(1'b1, `CRC_OFS_DATA, 32'h55555571, 4'h1, 1'b1, rd, err);
    u_master.xfer(1'b0, `CRC_OFS_SUM, 32'h0, 4'h0, 1'b0, rd, err);
    for (int i = 0; i < 7; i++) begin
      c = fold(c, bs[i], m);
    end
    check(rd, shown(c, m));
    check({31'h0, err}, 32'h00000000);
    $display("test mode %h done", m);
  endtask

  task automatic t_unit();
    logic [5:0] um [5] = '{6'h00, 6'h01, 6'h02, 6'h08, 6'h22};
    word_t ud [5] = '{32'h00000001, 32'h00000001, 32'h00000001, 32'h000000FE, 32'h00000001};
    word_t ue [5] = '{`CRC_POLY_CCITT, `CRC_POLY_16, `CRC_POLY_32, `CRC_POLY_CCITT, ~`CRC_POLY_32};
    word_t rd;
    logic err;
    for (int k = 0; k < 5; k++) begin
      u_master.xfer(1'b1, `CRC_OFS_MODE, {26'h0, um[k]}, 4'hF, 1'b1, rd, err);
      u_master.xfer(1'b1, `CRC_OFS_SEED, 32'h00000000, 4'hF, 1'b1, rd, err);
      u_master.xfer(1'b1, `CRC_OFS_DATA, ud[k], 4'h1, 1'b1, rd, err);
      u_master.xfer(1'b0, `CRC_OFS_SUM, 32'h0, 4'h0, 1'b0, rd, err);
      check(rd, ue[k]);
    end
    $display("test unit done");
  endtask

  task automatic t_busy();
    logic [3:0] s [3] = '{4'h1, 4'h3, 4'hF};
    word_t rd;
    logic err;
    int n;
    for (int k = 0; k < 3; k++) begin
      u_master.xfer(1'b1, `CRC_OFS_DATA, 32'h0, s[k], 1'b0, rd, err);
      n = 0;
      repeat (8) begin
        @(posedge CLK_I);
        if (BUSY_O === 1'b1) n++;
      end
      check(word_t'(n), (k == 2) ? 32'h4 : word_t'(k + 1));
    end
    $display("test busy done");
  endtask

  // ==========================================================================
  // Main sequence and timeout.
  initial begin
    repeat (10) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    t_reset();
    foreach (modes[i]) begin
      t_mode(modes[i]);
    end
    t_unit();
    t_busy();
    print_verdict();
  end

  always @(posedge CLK_I) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      print_verdict();
    end
  end
endmodule

// ---- core/crc_byte_step.sv ----
// Purpose: Folds one byte into the running checksum, most significant bit first.
// Assumes: Sixteen-bit checksums live in the low half of the word.
// Notes: Purely combinational.
`timescale 1ns/100ps
`include "crc_defs.svh"
module crc_byte_step (
  // Running value and input byte.
  input wire crc_pkg::word_t crc_i,
  input wire logic [7:0] byte_i,
  input wire crc_pkg::poly_t poly_i,
  // Updated value.
  output crc_pkg::word_t crc_o
);
  import crc_pkg::*;

  // ==========================================================================
  // Eight shift steps of the selected generator.
  function automatic word_t step8(input word_t c, input logic [7:0] d, input poly_t p);
    word_t gen;
    word_t r;
    logic wide;
    logic fb;
    gen = (p == POLY_CRC32) ? `CRC_POLY_32 : ((p == POLY_CRC16) ? `CRC_POLY_16 : `CRC_POLY_CCITT);
    wide = (p == POLY_CRC32);
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = (wide ? r[31] : r[15]) ^ d[i];
      r = {r[30:0], 1'b0};
      if (fb) begin
        r = r ^ gen;
      end
    end
    if (!wide) begin
      r[31:16] = 16'h0000;
    end
    return r;
  endfunction

  assign crc_o = step8(crc_i, byte_i, poly_i);

endmodule

// ---- core/crc_defs.svh ----
// Purpose: Offsets, field positions, reset values and generator constants of the CRC engine.
// Assumes: Included by bare name in each design file that needs it.
// Notes: Definitions only.
`ifndef CRC_DEFS_SVH
`define CRC_DEFS_SVH

// ==========================================================================
// Register offsets.
`define CRC_OFS_MODE 12'h000
`define CRC_OFS_SEED 12'h004
`define CRC_OFS_SUM 12'h008
`define CRC_OFS_DATA 12'h00C

// ==========================================================================
// Mode register fields.
`define CRC_MODE_POLY_LSB 0
`define CRC_MODE_POLY_MSB 1
`define CRC_MODE_REV_IN 2
`define CRC_MODE_INV_IN 3
`define CRC_MODE_REV_SUM 4
`define CRC_MODE_INV_SUM 5
`define CRC_MODE_W 6

// ==========================================================================
// Reset values.
`define CRC_MODE_RST 6'h00
`define CRC_SUM_RST 32'h0000FFFF
`define CRC_PRDATA_RST 32'h00000000

// ==========================================================================
// Generator polynomials, top term implied.
`define CRC_POLY_CCITT 32'h00001021
`define CRC_POLY_16 32'h00008005
`define CRC_POLY_32 32'h04C11DB7

`endif

// ---- core/crc_engine.sv ----
// Purpose: Programmable CRC engine with an APB register port.
// Assumes: APB4 master; PSTRB gives the width of a data write.
// Notes: One wait state per access, more while bytes are pending.
`timescale 1ns/100ps
`include "crc_defs.svh"
module crc_engine (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // APB slave.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire crc_pkg::word_t PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output crc_pkg::word_t PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Status.
  output logic BUSY_O
);
  import crc_pkg::*;

  // ==========================================================================
  // Helper functions.
  function automatic word_t rev32(input word_t v);
    word_t r;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31-i];
    end
    return r;
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  function automatic reg_sel_t decode(input logic [11:0] a);
    reg_sel_t s;
    if (a == `CRC_OFS_MODE) begin
      s = SEL_MODE;
    end else if (a == `CRC_OFS_SEED) begin
      s = SEL_SEED;
    end else if (a == `CRC_OFS_SUM) begin
      s = SEL_SUM;
    end else if (a == `CRC_OFS_DATA) begin
      s = SEL_DATA;
    end else begin
      s = SEL_NONE;
    end
    return s;
  endfunction

  // ==========================================================================
  // Declarations.
  logic [`CRC_MODE_W-1:0] mode_reg;
  word_t crc_reg;
  word_t crc_next;
  word_t prdata_reg;
  logic ack_reg;
  logic pslverr_reg;
  reg_sel_t sel;
  poly_t poly;
  logic rev_in;
  logic inv_in;
  logic rev_sum;
  logic inv_sum;
  logic wide;
  logic access;
  logic done;
  logic wr_ok;
  logic err;
  logic load;
  logic busy;
  logic step;
  logic [7:0] q_byte;
  logic [7:0] in_byte;
  word_t sum_out;
  word_t sum_rev;
  word_t rd_value;

  // ==========================================================================
  // Mode fields.
  assign poly = poly_t'(mode_reg[`CRC_MODE_POLY_MSB:`CRC_MODE_POLY_LSB]);
  assign rev_in = mode_reg[`CRC_MODE_REV_IN];
  assign inv_in = mode_reg[`CRC_MODE_INV_IN];
  assign rev_sum = mode_reg[`CRC_MODE_REV_SUM];
  assign inv_sum = mode_reg[`CRC_MODE_INV_SUM];
  assign wide = (poly == POLY_CRC32);

  // ==========================================================================
  // Bus phase decode.
  assign sel = decode(PADDR_I);
  assign access = PSEL_I & PENABLE_I;
  assign done = access & ack_reg;
  assign err = (sel == SEL_NONE) | (PWRITE_I & (sel == SEL_SUM));
  assign wr_ok = done & PWRITE_I & ~pslverr_reg;
  assign load = wr_ok & (sel == SEL_DATA) & (|PSTRB_I);

  // ==========================================================================
  // Pending byte lanes of a data write.
  crc_lane_queue #(
    .LANES(4)
  ) u_queue (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .load_i(load),
    .data_i(PWDATA_I),
    .strb_i(PSTRB_I),
    .byte_o(q_byte),
    .step_o(step),
    .busy_o(busy)
  );

  // ==========================================================================
  // Input byte transform and checksum step.
  always_comb begin
    in_byte = rev_in ? rev8(q_byte) : q_byte;
    if (inv_in) begin
      in_byte = ~in_byte;
    end
  end

  crc_byte_step u_step (
    .crc_i(crc_reg),
    .byte_i(in_byte),
    .poly_i(poly),
    .crc_o(crc_next)
  );

  // ==========================================================================
  // Result transform.
  assign sum_rev = rev32(crc_reg);

  always_comb begin
    sum_out = crc_reg;
    if (rev_sum) begin
      sum_out = wide ? sum_rev : {16'h0000, sum_rev[31:16]};
    end
    if (inv_sum) begin
      sum_out = ~sum_out;
    end
    if (!wide) begin
      sum_out[31:16] = 16'h0000;
    end
  end

  always_comb begin
    rd_value = 32'h00000000;
    if (sel == SEL_MODE) begin
      rd_value = {26'h0000000, mode_reg};
    end else if (sel == SEL_SUM) begin
      rd_value = sum_out;
    end
  end

  // ==========================================================================
  // Access acknowledge: waits while bytes are pending.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access & ~ack_reg & ~busy;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      prdata_reg <= `CRC_PRDATA_RST;
      pslverr_reg <= 1'b0;
    end else if (access & ~ack_reg & ~busy) begin
      prdata_reg <= PWRITE_I ? `CRC_PRDATA_RST : rd_value;
      pslverr_reg <= err;
    end else if (ack_reg) begin
      pslverr_reg <= 1'b0;
    end
  end

  assign PREADY_O = ack_reg;
  assign PRDATA_O = prdata_reg;
  assign PSLVERR_O = pslverr_reg;
  assign BUSY_O = busy;

  // ==========================================================================
  // Mode register.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mode_reg <= `CRC_MODE_RST;
    end else if (wr_ok & (sel == SEL_MODE) & PSTRB_I[0]) begin
      mode_reg <= PWDATA_I[`CRC_MODE_W-1:0];
    end
  end

  // ==========================================================================
  // Running checksum.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      crc_reg <= `CRC_SUM_RST;
    end else if (wr_ok & (sel == SEL_SEED)) begin
      crc_reg <= wide ? PWDATA_I : {16'h0000, PWDATA_I[15:0]};
    end else if (step) begin
      crc_reg <= crc_next;
    end
  end

  // ==========================================================================
  // Assertions.
  property p_ccitt;
    @(posedge CLK_I) disable iff (!RST_N_I)
      step && poly == POLY_CCITT && crc_reg == 32'h00000000 && in_byte == 8'h01
      |=> crc_reg == 32'h00001021;
  endproperty
  a_ccitt: assert property (p_ccitt) else $error("CCITT step result wrong.");

  property p_crc16;
    @(posedge CLK_I) disable iff (!RST_N_I)
      step && poly == POLY_CRC16 && crc_reg == 32'h00000000 && in_byte == 8'h01
      |=> crc_reg == 32'h00008005;
  endproperty
  a_crc16: assert property (p_crc16) else $error("CRC-16 step result wrong.");

  property p_crc32;
    @(posedge CLK_I) disable iff (!RST_N_I)
      step && poly == POLY_CRC32 && crc_reg == 32'h00000000 && in_byte == 8'h01
      |=> crc_reg == 32'h04C11DB7;
  endproperty
  a_crc32: assert property (p_crc32) else $error("CRC-32 step result wrong.");

  property p_inv_in;
    @(posedge CLK_I) disable iff (!RST_N_I)
      step && inv_in && !rev_in && poly == POLY_CCITT && crc_reg == 32'h00000000 && q_byte == 8'hFE
      |=> crc_reg == 32'h00001021;
  endproperty
  a_inv_in: assert property (p_inv_in) else $error("Input complement not applied.");

  property p_inv_sum;
    @(posedge CLK_I) disable iff (!RST_N_I)
      PREADY_O && !PWRITE_I && sel == SEL_SUM && inv_sum && !rev_sum && wide
      |-> PRDATA_O == ~crc_reg;
  endproperty
  a_inv_sum: assert property (p_inv_sum) else $error("Result complement not applied.");

  property p_byte1;
    @(posedge CLK_I) disable iff (!RST_N_I)
      load && PSTRB_I == 4'h1 |=> step ##1 !busy;
  endproperty
  a_byte1: assert property (p_byte1) else $error("Byte write not one cycle.");

  property p_half;
    @(posedge CLK_I) disable iff (!RST_N_I)
      load && PSTRB_I == 4'h3 |=> step [*2] ##1 !busy;
  endproperty
  a_half: assert property (p_half) else $error("Halfword write not two cycles.");

  property p_word;
    @(posedge CLK_I) disable iff (!RST_N_I)
      load && PSTRB_I == 4'hF |=> step [*4] ##1 !busy;
  endproperty
  a_word: assert property (p_word) else $error("Word write not four cycles.");

  property p_back2back;
    @(posedge CLK_I) disable iff (!RST_N_I)
      access && busy |-> !PREADY_O ##[1:5] PREADY_O;
  endproperty
  a_back2back: assert property (p_back2back) else $error("Pending access not completed.");

  property p_seed;
    @(posedge CLK_I) disable iff (!RST_N_I)
      wr_ok && sel == SEL_SEED && wide |=> crc_reg == $past(PWDATA_I) && !busy;
  endproperty
  a_seed: assert property (p_seed) else $error("Seed not loaded.");

  property p_sum_read;
    @(posedge CLK_I) disable iff (!RST_N_I)
      PREADY_O && !PWRITE_I && sel == SEL_SUM && !PSLVERR_O |-> !busy && PRDATA_O == sum_out;
  endproperty
  a_sum_read: assert property (p_sum_read) else $error("Sum read wrong or early.");

endmodule

// ---- core/crc_lane_queue.sv ----
// Purpose: Holds the byte lanes of one data write and releases them one per cycle.
// Assumes: A load only arrives while the queue is empty.
// Notes: Lanes go out lowest first; a disabled lane below the highest enabled one still takes its cycle.
`timescale 1ns/100ps
module crc_lane_queue #(
  parameter int LANES = 4
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Load side.
  input wire logic load_i,
  input wire logic [8*LANES-1:0] data_i,
  input wire logic [LANES-1:0] strb_i,
  // Drain side.
  output logic [7:0] byte_o,
  output logic step_o,
  output logic busy_o
);

  // ==========================================================================
  // Elaboration check.
  if (LANES < 2 || LANES > 8) begin : g_lanes_chk
    $error("crc_lane_queue: LANES must lie between 2 and 8.");
  end

  logic [8*LANES-1:0] data_reg;
  logic [LANES-1:0] strb_reg;

  // ==========================================================================
  // Shift register of pending lanes.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      data_reg <= '0;
      strb_reg <= '0;
    end else if (load_i) begin
      data_reg <= data_i;
      strb_reg <= strb_i;
    end else if (busy_o) begin
      data_reg <= {8'h00, data_reg[8*LANES-1:8]};
      strb_reg <= {1'b0, strb_reg[LANES-1:1]};
    end
  end

  assign byte_o = data_reg[7:0];
  assign step_o = strb_reg[0];
  assign busy_o = |strb_reg;

endmodule

// ---- core/crc_pkg.sv ----
// Purpose: Types shared by the CRC engine files.
// Assumes: Nothing.
// Notes: Constants live in crc_defs.svh.
package crc_pkg;

  // ==========================================================================
  // Polynomial selection.
  typedef enum logic [1:0] {
    POLY_CCITT = 2'b00,
    POLY_CRC16 = 2'b01,
    POLY_CRC32 = 2'b10
  } poly_t;

  // ==========================================================================
  // Register select after address decode.
  typedef enum logic [2:0] {
    SEL_MODE = 3'b000,
    SEL_SEED = 3'b001,
    SEL_SUM = 3'b010,
    SEL_DATA = 3'b011,
    SEL_NONE = 3'b100
  } reg_sel_t;

  typedef logic [31:0] word_t;

endpackage
